// file: logic/ghost_filter_consts.svh
// Purpose: constants for the key matrix ghost filter
// Assumes: 8 data lines by 8 commons, one scan per scan_done pulse
// Notes: counts and codes only; types live in ghost_filter_pkg
// Contract
// [R01] eight rows of 8-bit words, 1 is closed
// [R02] union word is OR of all rows
// [R03] zero union word reports no key pressed
// [R04] classify union as one, two, or more bits
// [R05] three or more active lines means invalid
// [R06] difference word is union minus row sum
// [R07] zero difference word means valid input
// [R08] nonzero difference with two lines is invalid
// [R09] one line: union plus difference zero is valid
// [R10] nonzero single-line sum means invalid input
// [R11] suppress presses once three or more detected
// [R12] two or fewer presses pass again
// [R13] forward words only when judged valid
// [R14] modulo-256 arithmetic, registered once per scan
`ifndef GHOST_FILTER_CONSTS_SVH
`define GHOST_FILTER_CONSTS_SVH
`define GF_ROWS 8
`define GF_LINES 8
`define GF_ZERO_WORD 8'h00
`define GF_ROW_IDX_W 3
`endif

// file: logic/ghost_filter_pkg.sv
// Purpose: types for the key matrix ghost filter
// Assumes: constants header included
// Notes: none
`include "ghost_filter_consts.svh"
package ghost_filter_pkg;
  typedef enum logic [1:0] {
    KEYS_NONE = 2'b00,
    KEYS_VALID = 2'b01,
    KEYS_INVALID = 2'b11
  } key_class_t;
  typedef logic [`GF_LINES-1:0] row_word_t;
endpackage : ghost_filter_pkg

// file: logic/line_count_class.sv
// Purpose: tell whether an 8-bit word has zero, one, two or more set bits
// Assumes: combinational, used on the union word
// Notes: bit-clearing trick avoids a popcount adder
`timescale 1ns/10ps
`include "ghost_filter_consts.svh"
module line_count_class (
  input wire logic [7:0] word,
  output logic is_zero,
  output logic is_one,
  output logic is_two
);
  logic [7:0] low_cleared;
  logic [7:0] low_cleared_twice;
  always_comb begin
    low_cleared = word & (word - 8'h01);
    low_cleared_twice = low_cleared & (low_cleared - 8'h01);
    is_zero = (word == `GF_ZERO_WORD); // R03
    is_one = !is_zero && (low_cleared == `GF_ZERO_WORD); // R04
    is_two = (low_cleared != `GF_ZERO_WORD) && (low_cleared_twice == `GF_ZERO_WORD); // R04
  end
endmodule : line_count_class

// file: logic/row_capture.sv
// Purpose: hold the eight row words of the scan in progress
// Assumes: row_valid carries one row word with its common index
// Notes: read data of the whole array comes out of registers
`timescale 1ns/10ps
module row_capture (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic row_valid,
  input wire logic [2:0] row_index,
  input wire logic [7:0] row_word,
  output logic [63:0] rows
);
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rows <= 64'h0000_0000_0000_0000;
    end else if (row_valid) begin
      rows[row_index*8 +: 8] <= row_word; // R01
    end
  end
endmodule : row_capture

// file: logic/matrix_key_ghost_filter.sv
// Purpose: reject ghosting key patterns of an 8x8 matrix scan
// Assumes: row inputs come from logic on clk; scan_done pulses after the eighth row
// Notes: result and forwarded rows update one cycle after scan_done
`timescale 1ns/10ps
`include "ghost_filter_consts.svh"
module matrix_key_ghost_filter (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic row_valid,
  input wire logic [2:0] row_index,
  input wire logic [7:0] row_word,
  input wire logic scan_done,
  output logic result_valid,
  output logic no_key,
  output logic key_valid,
  output logic key_invalid,
  output logic [63:0] key_input_base_byte,
  output logic [7:0] line_union_word,
  output logic [7:0] line_difference_word
);
  typedef struct packed {
    logic result_valid;
    ghost_filter_pkg::key_class_t cls;
    // decoded class flags kept in flops so the outputs need no logic
    logic nk;
    logic kv;
    logic ki;
    logic [63:0] fwd;
    logic [7:0] uni;
    logic [7:0] diff;
  } state_t;

  state_t st;
  state_t next_st;
  logic [63:0] rows;
  logic [7:0] union_c;
  logic [7:0] sum_c;
  logic [7:0] diff_c;
  logic [7:0] single_sum;
  logic is_zero;
  logic is_one;
  logic is_two;
  ghost_filter_pkg::key_class_t cls_c;

  row_capture i_row_capture (
    .clk(clk),
    .reset_n(reset_n),
    .row_valid(row_valid),
    .row_index(row_index),
    .row_word(row_word),
    .rows(rows)
  );

  line_count_class i_line_count_class (
    .word(union_c),
    .is_zero(is_zero),
    .is_one(is_one),
    .is_two(is_two)
  );

  // union and modulo-256 sum over all commons
  always_comb begin
    union_c = `GF_ZERO_WORD;
    sum_c = `GF_ZERO_WORD;
    for (int i = 0; i < `GF_ROWS; i++) begin
      union_c = union_c | rows[i*8 +: 8]; // R02
      sum_c = sum_c + rows[i*8 +: 8]; // R14
    end
    diff_c = union_c - sum_c; // R06
    single_sum = union_c + diff_c; // R09
  end

  // classification; recomputed every scan so releases restore validity
  always_comb begin
    if (is_zero) begin
      cls_c = ghost_filter_pkg::KEYS_NONE; // R03
    end else if (!(is_one || is_two)) begin
      cls_c = ghost_filter_pkg::KEYS_INVALID; // R05
    end else if (diff_c == `GF_ZERO_WORD) begin
      cls_c = ghost_filter_pkg::KEYS_VALID; // R07
    end else if (is_two) begin
      cls_c = ghost_filter_pkg::KEYS_INVALID; // R08
    end else if (single_sum == `GF_ZERO_WORD) begin
      cls_c = ghost_filter_pkg::KEYS_VALID; // R09
    end else begin
      cls_c = ghost_filter_pkg::KEYS_INVALID; // R10
    end
  end

  always_comb begin
    next_st = st;
    next_st.result_valid = scan_done; // R14
    if (scan_done) begin
      next_st.cls = cls_c;
      next_st.nk = (cls_c == ghost_filter_pkg::KEYS_NONE);
      next_st.kv = (cls_c == ghost_filter_pkg::KEYS_VALID);
      next_st.ki = (cls_c == ghost_filter_pkg::KEYS_INVALID);
      next_st.uni = union_c;
      next_st.diff = diff_c;
      // invalid scans keep the last good words so ghosts never leak out
      if (cls_c == ghost_filter_pkg::KEYS_VALID) begin
        next_st.fwd = rows; // R13 R12
      end else if (cls_c == ghost_filter_pkg::KEYS_NONE) begin
        next_st.fwd = 64'h0000_0000_0000_0000;
      end // R11
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st <= '{result_valid: 1'b0, cls: ghost_filter_pkg::KEYS_NONE,
              nk: 1'b1, kv: 1'b0, ki: 1'b0,
              fwd: 64'h0000_0000_0000_0000, uni: 8'h00, diff: 8'h00};
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    result_valid = st.result_valid;
    no_key = st.nk;
    key_valid = st.kv;
    key_invalid = st.ki;
    key_input_base_byte = st.fwd;
    line_union_word = st.uni;
    line_difference_word = st.diff;
  end

  a_none_on_zero: assert property (@(posedge clk) disable iff (!reset_n)
    scan_done && union_c == 8'h00 |=> no_key && !key_valid) // R03
    else $error("zero union not reported as no key");
  a_three_lines_bad: assert property (@(posedge clk) disable iff (!reset_n)
    scan_done && $countones(union_c) >= 3 |=> key_invalid) // R05
    else $error("three active lines not invalid");
  a_two_lines_diff: assert property (@(posedge clk) disable iff (!reset_n)
    scan_done && $countones(union_c) == 2 && diff_c != 8'h00 |=> key_invalid) // R08
    else $error("two lines with stacked keys not invalid");
  // one or two keys with no stacking, or exactly two keys on one line, are valid
  a_valid_count: assert property (@(posedge clk) disable iff (!reset_n)
    scan_done && union_c != 8'h00 |=>
      key_valid == ($countones($past(union_c)) <= 2 &&
      ($past(union_c) == $past(sum_c) ||
      ($countones($past(union_c)) == 1 && 8'($past(union_c) << 1) == $past(sum_c))))) // R07
    else $error("validity does not match key count");
  a_single_key: assert property (@(posedge clk) disable iff (!reset_n)
    scan_done && $countones(union_c) == 1 && sum_c == union_c |=> key_valid) // R04
    else $error("single key not valid");
  a_one_flag: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |-> $onehot({no_key, key_valid, key_invalid})) // R04
    else $error("class flags not one-hot");
  a_fwd_on_valid: assert property (@(posedge clk) disable iff (!reset_n)
    scan_done && cls_c == ghost_filter_pkg::KEYS_VALID |=> key_input_base_byte == $past(rows)) // R13
    else $error("valid rows not forwarded");
  a_hold_invalid: assert property (@(posedge clk) disable iff (!reset_n)
    scan_done && cls_c == ghost_filter_pkg::KEYS_INVALID |=> $stable(key_input_base_byte)) // R11
    else $error("invalid scan changed forwarded rows");
  a_diff_word: assert property (@(posedge clk) disable iff (!reset_n)
    scan_done |=> line_difference_word == $past(union_c) - $past(sum_c)) // R06
    else $error("difference word wrong");
  a_union_word: assert property (@(posedge clk) disable iff (!reset_n)
    scan_done |=> line_union_word == $past(union_c)) // R02
    else $error("union word wrong");
  a_result_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> result_valid == $past(scan_done)) // R14
    else $error("result pulse not one cycle after scan end");
endmodule : matrix_key_ghost_filter

// file: verification/key_matrix_model.sv
// Purpose: key matrix that reads out one common per cycle on a start pulse
// Assumes: keys row i at bits [8i+7:8i], 1 = closed switch
// Notes: word lines toggle when idle so a stale row is never mistaken
`timescale 1ns/10ps
module key_matrix_model (
  input wire logic clk,
  input wire logic start,
  input wire logic [63:0] keys,
  output logic row_valid,
  output logic [2:0] row_index,
  output logic [7:0] row_word,
  output logic scan_done
);
  logic [3:0] step;
  initial begin
    step = 4'h9;
    row_valid = 1'h0;
    row_index = 3'h0;
    row_word = 8'h00;
    scan_done = 1'h0;
  end
  always @(negedge clk) begin
    row_valid <= 1'h0;
    scan_done <= 1'h0;
    row_word <= ~row_word;
    if (start) begin
      step <= 4'h0;
    end else if (step < 4'h8) begin
      row_valid <= 1'h1;
      row_index <= step[2:0];
      row_word <= keys[8*step[2:0] +: 8];
      step <= step + 4'h1;
    end else if (step == 4'h8) begin
      scan_done <= 1'h1;
      step <= 4'h9;
    end
  end
endmodule : key_matrix_model

// file: verification/tb_matrix_key_ghost_filter.sv
// Purpose: self-checking bench for the key matrix ghost filter
// Assumes: model scans all eight commons per start pulse
// Notes: expected class is worked out here, bit by bit, per scan
`timescale 1ns/10ps
module tb_matrix_key_ghost_filter;
  logic clk, reset_n, start, row_valid, scan_done, result_valid, no_key, key_valid, key_invalid;
  logic [2:0] row_index;
  logic [7:0] row_word, line_union_word, line_difference_word;
  logic [63:0] keys, key_input_base_byte, fwd;
  int fails, tests_run;
  key_matrix_model i_key_matrix_model (.clk(clk), .start(start), .keys(keys),
    .row_valid(row_valid), .row_index(row_index), .row_word(row_word), .scan_done(scan_done));
  matrix_key_ghost_filter i_matrix_key_ghost_filter (.clk(clk), .reset_n(reset_n),
    .row_valid(row_valid), .row_index(row_index), .row_word(row_word), .scan_done(scan_done),
    .result_valid(result_valid), .no_key(no_key), .key_valid(key_valid),
    .key_invalid(key_invalid), .key_input_base_byte(key_input_base_byte),
    .line_union_word(line_union_word), .line_difference_word(line_difference_word));
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic scan(input logic [63:0] k);
    logic [7:0] u, s, d, r;
    logic v;
    int n, i;
    u = 8'h00;
    s = 8'h00;
    n = 0;
    for (i = 0; i < 8; i++) begin
      u = u | k[8*i +: 8];
      s = s + k[8*i +: 8];
    end
    d = u - s;
    r = u + d;
    for (i = 0; i < 8; i++) n += u[i];
    v = (u != 8'h00) && (n <= 2) && (d == 8'h00 || (n == 1 && r == 8'h00));
    if (u == 8'h00) fwd = 64'h0;
    else if (v) fwd = k;
    keys <= k;
    start <= 1'h1;
    @(negedge clk);
    start <= 1'h0;
    i = 0;
    while (result_valid !== 1'h1 && i < 20) begin
      @(negedge clk);
      i++;
    end
    chk("answer delay", 64'd10, 64'(i));
    chk("union", {56'h0, u}, {56'h0, line_union_word});
    chk("difference", {56'h0, d}, {56'h0, line_difference_word});
    chk("class", {61'h0, u == 8'h00, v, u != 8'h00 && !v},
      {61'h0, no_key, key_valid, key_invalid});
    chk("forwarded", fwd, key_input_base_byte);
  endtask : scan
  task automatic t_reset;
    chk("reset class", 64'h4, {61'h0, no_key, key_valid, key_invalid});
    chk("reset rows", 64'h0, key_input_base_byte);
  endtask : t_reset
  task automatic t_lines;
    scan(64'h0);
    for (int i = 0; i < 8; i++) scan(64'h1 << (24 + i));
    scan(64'h0000_0000_0000_1004);
    scan(64'h0000_0000_0020_1004);
  endtask : t_lines
  task automatic t_same_line;
    scan(64'h0000_0000_0000_0404);
    scan(64'h0000_0000_0004_0404);
  endtask : t_same_line
  task automatic t_two_lines;
    scan(64'h0000_0000_0010_0404);
    scan(64'h0000_0000_0010_0004);
    scan(64'h0);
  endtask : t_two_lines
  // sixteen scans of about a dozen cycles each fit well inside this span
  initial begin
    #40000;
    fails++;
    give_verdict();
  end
  initial begin
    reset_n = 1'h0;
    start = 1'h0;
    keys = 64'h0;
    fwd = 64'h0;
    fails = 0;
    tests_run = 0;
    repeat (8) @(negedge clk);
    reset_n <= 1'h1;
    t_reset();
    t_lines();
    t_same_line();
    t_two_lines();
    give_verdict();
  end
endmodule : tb_matrix_key_ghost_filter
